// ### hw/rtc_trim_map.vh
`ifndef RTC_TRIM_MAP_VH
`define RTC_TRIM_MAP_VH
// Register indices; each register is one aligned word, so its byte address is four times this
`define IDX_RESTART 16'h2010
`define IDX_COARSE_TOP 16'h201C
`define IDX_COARSE_MID 16'h201D
`define IDX_COARSE_LOW_FINE 16'h201E
`define IDX_STATUS 16'h2020
// Byte addresses on the register bus
`define ADDR_RESTART 16'h8040
`define ADDR_COARSE_TOP 16'h8070
`define ADDR_COARSE_MID 16'h8074
`define ADDR_COARSE_LOW_FINE 16'h8078
`define ADDR_STATUS 16'h8080
// Field positions
`define RESTART_BIT 0
`define COARSE_TOP_W 3
`define FINE_W 2
// Reset values
`define RST_COARSE_TOP 8'h04
`define RST_COARSE_MID 8'h00
`define RST_COARSE_LOW_FINE 8'h00
// Trim limits
`define COARSE_MIN 17'h0FFBF
`define COARSE_MAX 17'h10040
// Last sub-second count before the counter wraps to zero on the next 32 kHz tick
`define SUBSEC_TICKS 15'h7FFF
// 200 MHz to 32768 Hz tick divisor (integer part)
`define TICK_DIV 13'h17D7
`endif

// ### hw/subsec_counter.v
`timescale 1ns/1ps
`default_nettype none
module subsec_counter #(
	parameter WIDTH = 15
) (
	input wire aclk,
	input wire aresetn,
	input wire tick,
	input wire restart,
	output reg [WIDTH-1:0] count_q
);
	// Counts time-base ticks; restart wins over a tick
	always @(posedge aclk) begin
		if (!aresetn || restart) begin
			count_q <= {WIDTH{1'b0}};
		end else if (tick) begin
			count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule // subsec_counter
`default_nettype wire

// ### hw/rtc_rate_trim.v
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_trim_map.vh"
module rtc_rate_trim #(
	parameter TICK_DIV = `TICK_DIV
) (
	input wire aclk,
	input wire aresetn,
	input wire backup_ok,
	input wire sleep_mode,
	input wire [15:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [15:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [18:0] trim_value,
	output reg trim_active,
	output wire time_tick,
	output wire [14:0] subsec_count
);
	reg [7:0] coarse_top_q;
	reg [7:0] coarse_mid_q;
	reg [7:0] coarse_low_fine_q;
	reg [15:0] aw_addr_q;
	reg aw_full_q;
	reg [31:0] w_data_q;
	reg w_strb0_q;
	reg w_full_q;
	reg [12:0] div_q;
	reg restart_q;
	reg range_ok;
	wire do_write;
	wire [16:0] coarse;
	// Last divider count before it wraps
	localparam integer DIV_LAST = TICK_DIV - 1;
	// Three-stage synchronisers for the two level pins
	reg [2:0] backup_sync_q;
	reg backup_q;
	reg [2:0] sleep_sync_q;
	reg sleep_q;

	// Backup-supply pin: not cleared by the core reset, supply loss must act at any time
	always @(posedge aclk) begin
		backup_sync_q <= {backup_sync_q[1:0], backup_ok};
	end

	// Filtered backup level moves only once stages two and three agree
	always @(posedge aclk) begin
		if (backup_sync_q[1] == backup_sync_q[2]) begin
			backup_q <= backup_sync_q[2];
		end
	end

	// Sleep pin: same filter, cleared by the core reset
	always @(posedge aclk) begin
		if (!aresetn) begin
			sleep_sync_q <= 3'h0;
			sleep_q <= 1'b0;
		end else begin
			sleep_sync_q <= {sleep_sync_q[1:0], sleep_mode};
			if (sleep_sync_q[1] == sleep_sync_q[2]) begin
				sleep_q <= sleep_sync_q[2];
			end
		end
	end

	// Capture address and data independently, in either order
	assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
	assign s_axi_wready = !w_full_q && !s_axi_bvalid;
	assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= 16'h0000;
			w_data_q <= 32'h00000000;
			w_strb0_q <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb0_q <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_q == `ADDR_RESTART || aw_addr_q == `ADDR_COARSE_TOP ||
					aw_addr_q == `ADDR_COARSE_MID || aw_addr_q == `ADDR_COARSE_LOW_FINE ||
					aw_addr_q == `ADDR_STATUS) ? 2'h0 : 2'h2;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Trim fields: reset only while backup supply is lost; otherwise kept
	always @(posedge aclk) begin
		if (!backup_q) begin
			coarse_top_q <= `RST_COARSE_TOP;
			coarse_mid_q <= `RST_COARSE_MID;
			coarse_low_fine_q <= `RST_COARSE_LOW_FINE;
		end else if (do_write && w_strb0_q) begin
			// Separate byte fields, each loaded by a write to its own address
			if (aw_addr_q == `ADDR_COARSE_TOP)
				coarse_top_q <= {5'h00, w_data_q[2:0]};
			if (aw_addr_q == `ADDR_COARSE_MID)
				coarse_mid_q <= w_data_q[7:0];
			if (aw_addr_q == `ADDR_COARSE_LOW_FINE)
				coarse_low_fine_q <= w_data_q[7:0];
		end
	end

	// Restart pulse on a write of one only
	always @(posedge aclk) begin
		if (!aresetn) begin
			restart_q <= 1'b0;
		end else begin
			restart_q <= do_write && w_strb0_q && aw_addr_q == `ADDR_RESTART &&
				w_data_q[`RESTART_BIT];
		end
	end

	// Coarse in the upper 17 bits, fine in the low 2
	assign coarse = {coarse_top_q[2:0], coarse_mid_q, coarse_low_fine_q[7:2]};

	// Range check of what software programmed
	always @* begin
		range_ok = (coarse >= `COARSE_MIN) && (coarse <= `COARSE_MAX);
	end

	// Correction output, suppressed in sleep, values kept
	always @(posedge aclk) begin
		if (!aresetn) begin
			trim_value <= 19'h00000;
			trim_active <= 1'b0;
		end else begin
			trim_value <= {coarse, coarse_low_fine_q[1:0]};
			trim_active <= !sleep_q && range_ok;
		end
	end

	// 32 kHz time-base enable
	always @(posedge aclk) begin
		if (!aresetn || div_q == DIV_LAST[12:0]) begin
			div_q <= 13'h0000;
		end else begin
			div_q <= div_q + 13'h0001;
		end
	end
	assign time_tick = (div_q == 13'h0000);

	subsec_counter #(
		.WIDTH(15)
	) u_subsec (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(time_tick),
		.restart(restart_q),
		.count_q(subsec_count)
	);

	// Read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (s_axi_araddr)
				`ADDR_RESTART: s_axi_rdata <= 32'h00000000;
				`ADDR_COARSE_TOP: s_axi_rdata <= {24'h000000, coarse_top_q};
				`ADDR_COARSE_MID: s_axi_rdata <= {24'h000000, coarse_mid_q};
				`ADDR_COARSE_LOW_FINE: s_axi_rdata <= {24'h000000, coarse_low_fine_q};
				`ADDR_STATUS: s_axi_rdata <= {15'h0000, subsec_count, trim_active, range_ok};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // rtc_rate_trim
`default_nettype wire

// ### tb/rtc_trim_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_trim_assertions (
	input wire aclk,
	input wire aresetn,
	input wire backup_ok,
	input wire sleep_mode,
	input wire s_axi_bvalid,
	input wire [18:0] trim_value,
	input wire trim_active,
	input wire [14:0] subsec_count
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_sleep; sleep_mode && $past(sleep_mode) && $past(sleep_mode, 2) &&
		$past(sleep_mode, 3) && $past(sleep_mode, 4) |=> !trim_active; endproperty
	a_sleep: assert property (p_sleep) else $error("active in sleep");
	property p_in; trim_active |-> trim_value[18:2] >= 17'h0FFBF && trim_value[18:2] <= 17'h10040;
	endproperty
	a_in: assert property (p_in) else $error("active out of range");
	property p_out; !sleep_mode && !$past(sleep_mode) && !$past(sleep_mode, 2) &&
		!$past(sleep_mode, 3) && !$past(sleep_mode, 4) && !$past(sleep_mode, 5) &&
		!trim_active |->
		trim_value[18:2] < 17'h0FFBF || trim_value[18:2] > 17'h10040; endproperty
	a_out: assert property (p_out) else $error("idle in range");
	property p_hold; !s_axi_bvalid && backup_ok && $past(backup_ok) && $past(aresetn)
		|=> $stable(trim_value); endproperty
	a_hold: assert property (p_hold) else $error("trim changed");
	property p_cnt; $changed(subsec_count) && subsec_count != 15'h0
		|-> subsec_count == $past(subsec_count) + 15'h1; endproperty
	a_cnt: assert property (p_cnt) else $error("bad count step");
endmodule // rtc_trim_assertions
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic aclk = 0, aresetn = 0, backup_ok = 0, sleep_mode = 0, s_axi_bready = 1, s_axi_rready = 1;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, rdat;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] rrsp, brsp, f;
	logic [16:0] c;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, trim_active;
	wire time_tick;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [18:0] trim_value;
	wire [14:0] subsec_count;
	integer mismatches = 0, comparisons = 0, seed = 93, k;
	rtc_rate_trim #(.TICK_DIV(8)) i_rtc_rate_trim (.*);
	// Half-period toggle for 200 MHz
	always #2.5 aclk = ~aclk;
	task wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input string n, input [31:0] e, input [31:0] g);
		comparisons++;
		if (e !== g) begin
			mismatches++;
			$display("wrong value %s expected %0h seen %0h", n, e, g);
		end
	endtask
	// Write one byte; each channel is dropped once taken
	task wr(input [15:0] a, input [7:0] d);
		integer i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		for (i = 0; s_axi_bvalid !== 1'b1; i++) begin
			if (i > 99) begin
				mismatches++;
				wrap_up();
			end
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end
		brsp = s_axi_bresp;
	endtask
	// Read one word into rdat and rrsp
	task rd(input [15:0] a);
		integer i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		for (i = 0; s_axi_rvalid !== 1'b1; i++) begin
			if (i > 99) begin
				mismatches++;
				wrap_up();
			end
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end
		rdat = s_axi_rdata;
		rrsp = s_axi_rresp;
	endtask
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		backup_ok <= 1;
		rd(16'h8070); chk("top", 8'h04, rdat);
		rd(16'h8078); chk("low", 8'h00, rdat);
		rd(16'h8040); chk("restart", 8'h00, rdat);
		// First pass out of range, then random combined numbers in range
		for (k = 0; k < 4; k++) begin
			c = k ? 17'h0FFBF + $unsigned($random(seed)) % 130 : 17'h10041;
			f = $random(seed);
			wr(16'h8070, {5'h0, c[16:14]});
			wr(16'h8074, c[13:6]);
			wr(16'h8078, {c[5:0], f});
			repeat (2) @(posedge aclk);
			chk("trim", {c, f}, trim_value);
			chk("active", k != 0, trim_active);
		end
		// Core reset mid-run keeps stored trim
		aresetn <= 0;
		@(posedge aclk);
		aresetn <= 1;
		rd(16'h8074); chk("mid", c[13:6], rdat);
		sleep_mode <= 1;
		repeat (8) @(posedge aclk);
		chk("sleep", 0, trim_active);
		rd(16'h8078); chk("kept", {c[5:0], f}, rdat);
		sleep_mode <= 0;
		repeat (40) @(posedge aclk);
		chk("count runs", 1, subsec_count > 3);
		wr(16'h8040, 8'h01);
		chk("bresp", 2'h0, brsp);
		repeat (2) @(posedge aclk);
		chk("restart", 1, subsec_count < 2);
		repeat (40) @(posedge aclk);
		wr(16'h8040, 8'h00);
		repeat (2) @(posedge aclk);
		chk("no restart", 1, subsec_count > 3);
		// Loss of backup supply returns the trim fields to their reset values
		backup_ok <= 0;
		repeat (10) @(posedge aclk);
		backup_ok <= 1;
		repeat (6) @(posedge aclk);
		rd(16'h8070); chk("top lost", 8'h04, rdat);
		rd(16'h8074); chk("mid lost", 8'h00, rdat);
		wr(16'h8054, 8'h00); chk("bresp bad", 2'h2, brsp);
		rd(16'h8050); chk("resp", 2'h2, rrsp);
		chk("rdata bad", 0, rdat);
		wrap_up();
	end
endmodule // tb_top
bind rtc_rate_trim rtc_trim_assertions u_chk (.*);
`default_nettype wire
